/* inc/ltx_regs.svh */
// Register offsets, field positions, reset values and timing counts of the transmit encoder
`ifndef LTX_REGS_SVH
`define LTX_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define LTX_CH_STRIDE 8
`define LTX_TCFG0_OFS 8'h02
`define LTX_TCFG1_OFS 8'h03
`define LTX_TSTAT_OFS 8'h07
`define LTX_GCFG0_OFS 8'h40

// ****************************************
// Field positions
// ****************************************
`define LTX_CODER_BIT 0
`define LTX_RAIL_BIT 1
`define LTX_INV_BIT 2
`define LTX_EDGE_BIT 3
`define LTX_LOSS_MASK_BIT 4
`define LTX_STD_BIT 0
`define LTX_LOSS_LIVE_BIT 0
`define LTX_LOSS_STICKY_BIT 1

// ****************************************
// Reset values and write masks
// ****************************************
`define LTX_TCFG0_RST 8'h00
`define LTX_TCFG0_WMASK 8'h1F
`define LTX_TCFG1_RST 8'h00
`define LTX_TCFG1_WMASK 8'h0F
`define LTX_GCFG0_RST 8'h00
`define LTX_GCFG0_WMASK 8'h01

// ****************************************
// Timing counts
// ****************************************
`define LTX_CLK_LOSS_CYC 70
`define LTX_PIPE_DEPTH 8

`endif

/* inc/ltx_pkg.sv */
// Types shared by the transmit encoder
package ltx_pkg;

    // Line code applied to one channel
    typedef enum logic [1:0] {
        LTX_CODE_AMI,
        LTX_CODE_B8ZS,
        LTX_CODE_HDB3,
        LTX_CODE_BYPASS
    } ltx_code_t;

endpackage : ltx_pkg

/* core/ltx_encoder.sv */
// Transmit system interface and line encoder for all channels
//
// Behaviour
// - Global standard bit: 0 runs all channels E1, 1 runs T1/J1.
// - Transmit clock absent over 70 clock cycles flags an alarm unless masked.
// - Data sampled on the transmit clock edge picked by edge select bit.
// - Data invert bit picks active high or active low data.
// - Rail mode 0: single rail, data from the data pin only.
// - Rail mode 1: dual rail, data from positive and negative rail pins.
// - T1/J1 single rail: coder select picks B8ZS or AMI.
// - E1 single rail: coder select picks HDB3 or AMI.
// - Dual rail bypasses the coder, symbols come straight from rails.
// - Positive rail 1, negative rail 0 gives a negative pulse.
// - Positive rail 0, negative rail 1 gives a positive pulse.
// - Equal rail levels give a space.
// - Pulse shape comes from a preset or a user waveform template.
// - T1 offers five preset templates chosen by the template field.
// - Template field 11xx selects the user waveform for that channel.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`include "ltx_regs.svh"

module ltx_encoder
    import ltx_pkg::*;
#(
    parameter int NUM_CH = 8,
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input logic clock,
    input logic rst,
    // Register port
    input logic [ADDR_W-1:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [7:0] reg_rdata,
    // System transmit pins
    input logic [NUM_CH-1:0] tx_clock_in,
    input logic [NUM_CH-1:0] tx_data_or_pos_rail,
    input logic [NUM_CH-1:0] tx_neg_rail,
    // Line symbols
    output logic [NUM_CH-1:0] line_out_tip,
    output logic [NUM_CH-1:0] line_out_ring,
    // Pulse shaper selection
    output logic [4*NUM_CH-1:0] tx_template,
    output logic [NUM_CH-1:0] tx_arb_wave,
    // Clock loss alarm
    output logic [NUM_CH-1:0] tx_clk_loss_alarm
);

    // ****************************************
    // Global configuration
    // ****************************************
    logic [7:0] gcfg0_r;
    logic [7:0] gcfg0_nxt;
    logic line_standard_select;
    logic [8*NUM_CH-1:0] cfg0_all;
    logic [8*NUM_CH-1:0] cfg1_all;
    logic [2*NUM_CH-1:0] stat_all;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Global register write
    always_comb
    begin
        gcfg0_nxt = gcfg0_r;
        if (reg_wr && reg_addr == ADDR_W'(`LTX_GCFG0_OFS))
        begin
            gcfg0_nxt = reg_wdata & `LTX_GCFG0_WMASK;
        end
    end

    // Global register store
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            gcfg0_r <= `LTX_GCFG0_RST;
        end
        else
        begin
            gcfg0_r <= gcfg0_nxt;
        end
    end

    assign line_standard_select = gcfg0_r[`LTX_STD_BIT];

    // ****************************************
    // Register read
    // ****************************************
    // Read data mux, unmapped reads give zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == ADDR_W'(`LTX_GCFG0_OFS))
            begin
                rdata_nxt = gcfg0_r;
            end
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (reg_addr == ADDR_W'(i * `LTX_CH_STRIDE + `LTX_TCFG0_OFS))
                begin
                    rdata_nxt = cfg0_all[8*i +: 8];
                end
                if (reg_addr == ADDR_W'(i * `LTX_CH_STRIDE + `LTX_TCFG1_OFS))
                begin
                    rdata_nxt = cfg1_all[8*i +: 8];
                end
                if (reg_addr == ADDR_W'(i * `LTX_CH_STRIDE + `LTX_TSTAT_OFS))
                begin
                    rdata_nxt = {6'h00, stat_all[2*i +: 2]};
                end
            end
        end
    end

    // Read data register
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ****************************************
    // Per channel path
    // ****************************************
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        localparam logic [ADDR_W-1:0] BASE = ADDR_W'(c * `LTX_CH_STRIDE);
        logic [2:0] clk_sy_r, clk_sy_nxt;
        logic [1:0] dp_sy_r, dp_sy_nxt;
        logic [1:0] dn_sy_r, dn_sy_nxt;
        logic [7:0] cfg0_r, cfg0_nxt;
        logic [7:0] cfg1_r, cfg1_nxt;
        logic [6:0] loss_cnt_r, loss_cnt_nxt;
        logic loss_r, loss_nxt;
        logic sticky_r, sticky_nxt;
        logic alarm_r, alarm_nxt;
        logic [`LTX_PIPE_DEPTH-1:0] d_r, d_nxt;
        logic [`LTX_PIPE_DEPTH-1:0] f_r, f_nxt;
        logic [`LTX_PIPE_DEPTH-1:0] sp_r, sp_nxt;
        logic [`LTX_PIPE_DEPTH-1:0] sn_r, sn_nxt;
        logic last_pos_r, last_pos_nxt;
        logic odd_r, odd_nxt;
        logic tip_r, tip_nxt;
        logic ring_r, ring_nxt;
        logic arb_r, arb_nxt;
        logic tick;
        logic bit_in;
        logic neg_in;
        ltx_code_t code;

        // Active edge of the synchronised clock, rising or falling by the edge bit
        assign tick = (clk_sy_r[1] ^ clk_sy_r[2]) & (clk_sy_r[1] ^ cfg0_r[`LTX_EDGE_BIT]);

        // Data level decode of both rail pins by the invert bit
        assign bit_in = dp_sy_r[1] ^ cfg0_r[`LTX_INV_BIT];
        assign neg_in = dn_sy_r[1] ^ cfg0_r[`LTX_INV_BIT];

        // Coder choice from rail mode, coder bit and line standard
        always_comb
        begin
            if (cfg0_r[`LTX_RAIL_BIT])
            begin
                code = LTX_CODE_BYPASS;
            end
            else if (!cfg0_r[`LTX_CODER_BIT])
            begin
                code = LTX_CODE_AMI;
            end
            else if (line_standard_select)
            begin
                code = LTX_CODE_B8ZS;
            end
            else
            begin
                code = LTX_CODE_HDB3;
            end
        end

        // Synchronisers, configuration and clock loss watch
        always_comb
        begin
            clk_sy_nxt = {clk_sy_r[1:0], tx_clock_in[c]};
            dp_sy_nxt = {dp_sy_r[0], tx_data_or_pos_rail[c]};
            dn_sy_nxt = {dn_sy_r[0], tx_neg_rail[c]};
            cfg0_nxt = cfg0_r;
            cfg1_nxt = cfg1_r;
            if (reg_wr && reg_addr == BASE + ADDR_W'(`LTX_TCFG0_OFS))
            begin
                cfg0_nxt = reg_wdata & `LTX_TCFG0_WMASK;
            end
            if (reg_wr && reg_addr == BASE + ADDR_W'(`LTX_TCFG1_OFS))
            begin
                cfg1_nxt = reg_wdata & `LTX_TCFG1_WMASK;
            end
            arb_nxt = &cfg1_nxt[3:2];
            // Count cycles since the last clock transition
            loss_cnt_nxt = loss_cnt_r;
            loss_nxt = loss_r;
            if (clk_sy_r[1] ^ clk_sy_r[2])
            begin
                loss_cnt_nxt = 7'h00;
                loss_nxt = 1'b0;
            end
            else if (loss_cnt_r == 7'(`LTX_CLK_LOSS_CYC))
            begin
                loss_nxt = 1'b1;
            end
            else
            begin
                loss_cnt_nxt = loss_cnt_r + 7'h01;
            end
            // Sticky flag, write one clears, a new loss wins
            sticky_nxt = sticky_r;
            if (reg_wr && reg_addr == BASE + ADDR_W'(`LTX_TSTAT_OFS)
                && reg_wdata[`LTX_LOSS_STICKY_BIT])
            begin
                sticky_nxt = 1'b0;
            end
            if (loss_nxt)
            begin
                sticky_nxt = 1'b1;
            end
            alarm_nxt = sticky_nxt & ~cfg0_nxt[`LTX_LOSS_MASK_BIT];
        end

        // Line coder, one step per active clock edge
        always_comb
        begin
            d_nxt = d_r;
            f_nxt = f_r;
            sp_nxt = sp_r;
            sn_nxt = sn_r;
            last_pos_nxt = last_pos_r;
            odd_nxt = odd_r;
            tip_nxt = tip_r;
            ring_nxt = ring_r;
            if (tick && code == LTX_CODE_BYPASS)
            begin
                tip_nxt = ~bit_in & neg_in;
                ring_nxt = bit_in & ~neg_in;
            end
            else if (tick)
            begin
                // Eight zero run becomes 000VB0VB
                if (code == LTX_CODE_B8ZS && d_nxt == 8'h00 && f_nxt == 8'h00)
                begin
                    f_nxt = 8'hFF;
                    sp_nxt = {3'b000, last_pos_r, ~last_pos_r, 1'b0, ~last_pos_r, last_pos_r};
                    sn_nxt = {3'b000, ~last_pos_r, last_pos_r, 1'b0, last_pos_r, ~last_pos_r};
                end
                // Four zero run becomes 000V or B00V
                if (code == LTX_CODE_HDB3 && d_nxt[7:4] == 4'h0 && f_nxt[7:4] == 4'h0)
                begin
                    f_nxt[7:4] = 4'hF;
                    if (odd_r)
                    begin
                        sp_nxt[7:4] = {3'b000, last_pos_r};
                        sn_nxt[7:4] = {3'b000, ~last_pos_r};
                    end
                    else
                    begin
                        sp_nxt[7:4] = {~last_pos_r, 2'b00, ~last_pos_r};
                        sn_nxt[7:4] = {last_pos_r, 2'b00, last_pos_r};
                    end
                end
                // Oldest slot goes to the line
                if (f_nxt[7])
                begin
                    tip_nxt = sp_nxt[7];
                    ring_nxt = sn_nxt[7];
                end
                else
                begin
                    tip_nxt = d_nxt[7] & ~last_pos_r;
                    ring_nxt = d_nxt[7] & last_pos_r;
                end
                // Polarity memory and pulse parity since last violation
                if (tip_nxt | ring_nxt)
                begin
                    last_pos_nxt = tip_nxt;
                    odd_nxt = (tip_nxt == last_pos_r) ? 1'b0 : ~odd_r;
                end
                d_nxt = {d_nxt[6:0], bit_in};
                f_nxt = {f_nxt[6:0], 1'b0};
                sp_nxt = {sp_nxt[6:0], 1'b0};
                sn_nxt = {sn_nxt[6:0], 1'b0};
            end
        end

        // Channel state store
        always_ff @(posedge clock)
        begin
            if (rst)
            begin
                clk_sy_r <= 3'h0;
                dp_sy_r <= 2'h0;
                dn_sy_r <= 2'h0;
                cfg0_r <= `LTX_TCFG0_RST;
                cfg1_r <= `LTX_TCFG1_RST;
                loss_cnt_r <= 7'h00;
                loss_r <= 1'b0;
                sticky_r <= 1'b0;
                alarm_r <= 1'b0;
                d_r <= 8'h00;
                f_r <= 8'h00;
                sp_r <= 8'h00;
                sn_r <= 8'h00;
                last_pos_r <= 1'b0;
                odd_r <= 1'b0;
                tip_r <= 1'b0;
                ring_r <= 1'b0;
                arb_r <= 1'b0;
            end
            else
            begin
                clk_sy_r <= clk_sy_nxt;
                dp_sy_r <= dp_sy_nxt;
                dn_sy_r <= dn_sy_nxt;
                cfg0_r <= cfg0_nxt;
                cfg1_r <= cfg1_nxt;
                loss_cnt_r <= loss_cnt_nxt;
                loss_r <= loss_nxt;
                sticky_r <= sticky_nxt;
                alarm_r <= alarm_nxt;
                d_r <= d_nxt;
                f_r <= f_nxt;
                sp_r <= sp_nxt;
                sn_r <= sn_nxt;
                last_pos_r <= last_pos_nxt;
                odd_r <= odd_nxt;
                tip_r <= tip_nxt;
                ring_r <= ring_nxt;
                arb_r <= arb_nxt;
            end
        end

        // Register view and outputs of the channel
        assign cfg0_all[8*c +: 8] = cfg0_r;
        assign cfg1_all[8*c +: 8] = cfg1_r;
        assign stat_all[2*c +: 2] = {sticky_r, loss_r};
        assign line_out_tip[c] = tip_r;
        assign line_out_ring[c] = ring_r;
        assign tx_template[4*c +: 4] = cfg1_r[3:0];
        assign tx_arb_wave[c] = arb_r;
        assign tx_clk_loss_alarm[c] = alarm_r;
    end

endmodule : ltx_encoder

/* dv/ltx_encoder_sva.sv */
// Port checker for the transmit encoder
`timescale 1ns/100ps
module ltx_encoder_sva
#(
    parameter int NUM_CH = 8,
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Line side
    input wire logic [NUM_CH-1:0] tx_clock_in,
    input wire logic [NUM_CH-1:0] line_out_tip,
    input wire logic [NUM_CH-1:0] line_out_ring,
    input wire logic [4*NUM_CH-1:0] tx_template,
    input wire logic [NUM_CH-1:0] tx_arb_wave,
    input wire logic [NUM_CH-1:0] tx_clk_loss_alarm
);
    logic clk0_r, clk0_nxt;
    logic [7:0] idle_r, idle_nxt;
    logic [3:0] tpl_r, tpl_nxt;
    logic [NUM_CH-1:0] arb_exp;

    // Idle time of channel 0 pin, last template written
    always_comb
    begin
        clk0_nxt = tx_clock_in[0];
        idle_nxt = (tx_clock_in[0] != clk0_r) ? 8'h00 : idle_r + {7'h00, ~&idle_r};
        tpl_nxt = (reg_wr && reg_addr == 8'h03) ? reg_wdata[3:0] : tpl_r;
        for (int c = 0; c < NUM_CH; c++)
            arb_exp[c] = &tx_template[4*c+2 +: 2];
    end
    always_ff @(posedge clock)
    begin
        clk0_r <= clk0_nxt;
        tpl_r <= tpl_nxt;
        idle_r <= rst ? 8'h00 : idle_nxt;
    end

    // Mapped register places
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == 8'h40 || (a < 8'h40 && (a[2:0] == 3'h2 || a[2:0] == 3'h3 || a[2:0] == 3'h7));
    endfunction : mapped

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    chk_unmapped_zero: assert property (reg_rd && !mapped(reg_addr) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_global_bits: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata[7:1] == 7'h00)
        else $error("global config spare bits set");
    chk_tpl_bits: assert property (reg_rd && reg_addr[2:0] == 3'h3 |=> reg_rdata[7:4] == 4'h0)
        else $error("template spare bits set");
    chk_tpl_follow: assert property (reg_wr && reg_addr == 8'h03 |-> ##[1:2] tx_template[3:0] == tpl_r)
        else $error("template output not updated");
    chk_arb_wave: assert property (tx_arb_wave == arb_exp)
        else $error("user waveform flag wrong");
    chk_sym_excl: assert property ((line_out_tip & line_out_ring) == '0)
        else $error("tip and ring both high");
    chk_loss_wait: assert property ($rose(tx_clk_loss_alarm[0]) && !$past(reg_wr) && !$past(reg_wr, 2)
        |-> idle_r >= 8'd70)
        else $error("loss alarm too early");
    chk_out_hold: assert property (idle_r > 8'd6 |-> $stable(line_out_tip[0]) && $stable(line_out_ring[0]))
        else $error("symbol changed without clock edge");

    cover property ($rose(tx_clk_loss_alarm[0]));
    cover property (line_out_tip[0]);
    cover property (line_out_ring[0]);
    cover property (tx_arb_wave[0]);
endmodule : ltx_encoder_sva

/* dv/ltx_framer_model.sv */
// Framer model driving transmit bit clock and data
`timescale 1ns/100ps
module ltx_framer_model
(
    // Control from the bench
    input wire logic run,
    input wire logic chg_on_rise,
    input wire logic [7:0] pos_val,
    input wire logic [7:0] neg_val,
    // Transmit pins
    output logic [7:0] tx_clock_in,
    output logic [7:0] tx_data_or_pos_rail,
    output logic [7:0] tx_neg_rail
);
    logic clk_r;

    // Bit clock, stands still low between frames
    initial
    begin
        clk_r = 1'b0;
        tx_data_or_pos_rail = 8'h00;
        tx_neg_rail = 8'h00;
        #7;
        forever
        begin
            #80;
            if (run || clk_r)
                clk_r = ~clk_r;
        end
    end
    assign tx_clock_in = {8{clk_r}};

    // Data launched on the edge away from the sampling edge
    always @(clk_r)
    begin
        if (clk_r == chg_on_rise)
        begin
            tx_data_or_pos_rail = pos_val;
            tx_neg_rail = neg_val;
        end
    end
endmodule : ltx_framer_model

/* dv/tb.sv */
// Self-checking bench for the transmit encoder
`timescale 1ns/100ps
module tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run = 1'b0;
    logic chg_on_rise = 1'b0;
    logic [7:0] pos_val = 8'h00;
    logic [7:0] neg_val = 8'h00;
    logic [7:0] reg_rdata, tclk, tdat, tneg, tip, ring, arb, alarm, rv;
    logic [31:0] tpl;
    logic [1:0] sym;
    logic [2:0] hist = 3'h0;
    logic lastpol = 1'b0;
    logic [3:0] tpls [5] = '{4'h0, 4'h1, 4'h7, 4'hC, 4'hF};
    int failures = 0;
    int n_tests = 0;
    int pulses, trip, viol;

    always #10 clock = ~clock;

    ltx_encoder #(.NUM_CH(8), .ADDR_W(8)) ltx_encoder_inst (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_clock_in(tclk),
        .tx_data_or_pos_rail(tdat), .tx_neg_rail(tneg), .line_out_tip(tip),
        .line_out_ring(ring), .tx_template(tpl), .tx_arb_wave(arb), .tx_clk_loss_alarm(alarm));
    ltx_framer_model ltx_framer_model_inst (.run(run), .chg_on_rise(chg_on_rise),
        .pos_val(pos_val), .neg_val(neg_val), .tx_clock_in(tclk),
        .tx_data_or_pos_rail(tdat), .tx_neg_rail(tneg));

    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s seen %0h exp %0h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Symbols of channel 0, one per bit, with history across calls
    task automatic measure(input int n);
        pulses = 0;
        trip = 0;
        viol = 0;
        repeat (n)
        begin
            @(posedge tclk[0]);
            sym = {tip[0], ring[0]};
            hist = {hist[1:0], sym == 2'b00};
            if (&hist)
                trip++;
            if (sym != 2'b00)
            begin
                pulses++;
                if (tip[0] == lastpol)
                    viol++;
                lastpol = tip[0];
            end
        end
    endtask : measure
    task automatic code_case(input logic [7:0] g, input logic [7:0] c, input logic [7:0] p,
        input logic [31:0] ep, input logic [31:0] et, input logic [31:0] ev);
        wr(8'h40, g);
        wr(8'h02, c);
        pos_val <= p;
        measure(24);
        measure(16);
        chk(pulses, ep, "pulses");
        chk(trip, et, "zero triples");
        chk(viol, ev, "violations");
    endtask : code_case
    task automatic dual_case(input logic [7:0] c, input logic [7:0] p, input logic [7:0] n,
        input logic [1:0] es);
        wr(8'h02, c);
        pos_val <= p;
        neg_val <= n;
        measure(4);
        chk(sym, es, "dual rail symbol");
    endtask : dual_case
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (80) @(posedge clock);
        chk(alarm, 8'hFF, "loss alarm");
        rd(8'h07, rv);
        chk(rv, 8'h03, "loss status");
        wr(8'h3A, 8'h10);
        repeat (3) @(posedge clock);
        chk(alarm, 8'h7F, "masked alarm");
        wr(8'h1A, 8'hFF);
        rd(8'h1A, rv);
        chk(rv, 8'h1F, "config zero");
        wr(8'h40, 8'hFF);
        rd(8'h40, rv);
        chk(rv, 8'h01, "global config");
        rd(8'h41, rv);
        chk(rv, 8'h00, "unmapped");
        rd(8'h05, rv);
        chk(rv, 8'h00, "unmapped");
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h03, {4'hF, tpls[i]});
            rd(8'h03, rv);
            chk(rv, {4'h0, tpls[i]}, "template read");
            chk(tpl[3:0], tpls[i], "template pins");
            chk(arb[0], &tpls[i][3:2], "user waveform");
        end
        neg_val <= 8'hFF;
        run <= 1'b1;
        code_case(8'h01, 8'h00, 8'hFF, 16, 0, 0);
        wr(8'h07, 8'h02);
        repeat (3) @(posedge clock);
        chk(alarm, 8'h76, "cleared alarm");
        code_case(8'h01, 8'h04, 8'hFF, 0, 16, 0);
        code_case(8'h01, 8'h00, 8'h00, 0, 16, 0);
        code_case(8'h01, 8'h01, 8'h00, 8, 2, 4);
        code_case(8'h00, 8'h01, 8'h00, 8, 0, 4);
        dual_case(8'h02, 8'hFF, 8'h00, 2'b01);
        dual_case(8'h02, 8'h00, 8'hFF, 2'b10);
        dual_case(8'h02, 8'hFF, 8'hFF, 2'b00);
        dual_case(8'h02, 8'h00, 8'h00, 2'b00);
        dual_case(8'h06, 8'hFF, 8'h00, 2'b10);
        chg_on_rise <= 1'b1;
        dual_case(8'h0A, 8'hFF, 8'h00, 2'b01);
        run <= 1'b0;
        repeat (100) @(posedge clock);
        chk(alarm, 8'h77, "loss again");
        end_of_test();
    end

    // Watchdog
    initial
    begin
        #400000;
        failures++;
        $display("mismatch at %0t: run did not finish", $time);
        end_of_test();
    end
endmodule : tb

bind ltx_encoder ltx_encoder_sva #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) ltx_encoder_sva_inst (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_clock_in(tx_clock_in),
    .line_out_tip(line_out_tip), .line_out_ring(line_out_ring), .tx_template(tx_template),
    .tx_arb_wave(tx_arb_wave), .tx_clk_loss_alarm(tx_clk_loss_alarm));
